// *** verilog/rssg_defines.vh ***
`ifndef RSSG_DEFINES_VH
`define RSSG_DEFINES_VH
// Wishbone register offsets (byte addresses)
`define RSSG_REG_CTRL      8'h00
`define RSSG_REG_STATUS    8'h04
`define RSSG_REG_MSTEP     8'h08
// Control field positions and reset value
`define RSSG_CTRL_ENABLE   0
`define RSSG_CTRL_DELETE   1
`define RSSG_CTRL_RESET    2'h1
// Status field positions
`define RSSG_ST_GRANT_LSB  0
`define RSSG_ST_VALID      3
`define RSSG_ST_STOP       4
`define RSSG_ST_SS1        5
`define RSSG_ST_SS2        6
// Timing
`define RSSG_CLK_MHZ       50
`define RSSG_STEP_DELAY_US 50
`define RSSG_STEP_DELAY_CYC (`RSSG_STEP_DELAY_US * `RSSG_CLK_MHZ)
`endif

// *** verilog/rssg_sync.v ***
`timescale 1ns/100ps
module rssg_sync #(
    parameter W = 1
) (
    // Clock
    input  wire         clk_i,
    // Async level in, synchronised level out
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;
    always @(posedge clk_i) begin
        meta_r <= d_i;
        sync_r <= meta_r;
    end
    assign q_o = sync_r;
endmodule // rssg_sync

// *** verilog/rssg_top.v ***
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/100ps
// Function
// R1: At most one of the six readers is granted the line at any time.
// R2: A reader bids by holding its bid input low; bid primes grant.
// R3: Grant sets when slot counter decodes step three with character clock, bid primed.
// R4: Granted reader's slot counter ignores step pulses until grant ends.
// R5: Granted reader gets active-low on-line and contact sampling enable.
// R6: Finished reader hands grant to next reader in numeric order.
// R7: Steps go to message-start generator normally, to reader in delete mode.
// R8: Normal mode: read pulses become generator steps, reader step stays idle.
// R9: Once delete-prime falls, steps go to granted reader and alarm logic.
// R10: Each incoming low reader step starts a 50 us delay.
// R11: At delay end one delayed step passes unless a stop is active.
// R12: Stop is OR of master stop, five supplementary stops, alarm, remote stop.
// R13: Any active stop suppresses delayed step pulses.
// R14: Stop present at grant step time blocks the delayed step 50 us later.
// R15: Manual step request primes first single-step flop, set by next step.
// R16: Second single-step flop, set next, forces step gate open despite stop.
// R17: Each manual request yields exactly one normally timed output step.
// R18: Single-step flops return to rest through normal step flow.
// R19: After second flop sets, next step clears both flops.
// R20: Remote stop-send also blocks the step-read pulse.
// R21: Grant order wraps from six to one and skips non-bidding slots.
// R22: Asynchronous bid, stop and manual inputs pass a two-flop synchroniser.
`include "rssg_defines.vh"
module rssg_top #(
    parameter NRD      = 6,
    parameter DLY_CYC  = `RSSG_STEP_DELAY_CYC
) (
    // Clock and reset
    input  wire           clk_i,
    input  wire           rst_i,
    // Wishbone slave
    input  wire           cyc_i,
    input  wire           stb_i,
    input  wire           we_i,
    input  wire [7:0]     adr_i,
    input  wire [3:0]     sel_i,
    input  wire [31:0]    dat_i,
    output reg  [31:0]    dat_o,
    output reg            ack_o,
    // Reader side (asynchronous)
    input  wire [NRD-1:0] bid_n_i,
    input  wire [NRD-1:0] stop_n_i,
    input  wire [NRD-1:0] manual_step_i,
    input  wire [NRD-1:0] tx_done_i,
    input  wire           delete_prime_n_i,
    input  wire           remote_stop_n_i,
    input  wire           alarm_n_i,
    // Converter and timing (same clock)
    input  wire           reader_step_n_i,
    input  wire           char_clk_i,
    input  wire           read_pulse_i,
    // Outputs
    output reg  [NRD-1:0] online_n_o,
    output reg  [NRD-1:0] contact_en_o,
    output reg  [NRD-1:0] reader_step_o,
    output reg            som_step_n_o,
    output reg            alarm_step_o,
    output reg            step_out_o,
    output reg            step_read_o
);
    localparam GW = 3;
    localparam DW = 12;
    // Timer width covers the default delay; widen DW for slower steps
    localparam [31:0]   DLY_M1     = DLY_CYC - 1;
    localparam [DW-1:0] DLY_LAST   = DLY_M1[DW-1:0];
    // Slot counter codes
    localparam [1:0]    SLOT_IDLE  = 2'h0;
    localparam [1:0]    SLOT_THIRD = 2'h3;

    // Synchronised asynchronous inputs
    wire [NRD-1:0] bid_n_s;
    wire [NRD-1:0] stop_n_s;
    wire [NRD-1:0] man_s;
    wire [NRD-1:0] done_s;
    wire           del_n_s;
    wire           rstop_n_s;
    wire           alarm_n_s;
    // Other equipment drives these; two flops guard against metastability
    wire [4*NRD+2:0] async_in = {bid_n_i, stop_n_i, manual_step_i, tx_done_i,
                                 delete_prime_n_i, remote_stop_n_i, alarm_n_i};
    rssg_sync #(.W(4*NRD+3)) u_sync ( // [R22]
        .clk_i (clk_i),
        .d_i   (async_in),
        .q_o   ({bid_n_s, stop_n_s, man_s, done_s, del_n_s, rstop_n_s, alarm_n_s})
    );

    // Registers
    reg  [1:0]     ctrl_r;
    reg  [NRD-1:0] mstep_r;
    wire           enable   = ctrl_r[`RSSG_CTRL_ENABLE];
    wire           delete_m = ctrl_r[`RSSG_CTRL_DELETE] | ~del_n_s;

    // Step edge detect on local incoming step
    // Held at the pin's idle level in reset, so no false step follows
    reg            step_d_r;
    wire           step_in  = ~reader_step_n_i & step_d_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            step_d_r <= 1'b1;
        end else begin
            step_d_r <= reader_step_n_i;
        end
    end

    // Grant state
    reg  [GW-1:0]  grant_r;
    reg            gvalid_r;
    reg  [1:0]     slot_cnt_r [0:NRD-1];
    reg  [GW-1:0]  ptr_r;

    // Low bid primes its slot
    wire [NRD-1:0] bid_prime = ~bid_n_s; // [R2]
    // A slot restarts from idle once its reader releases the line
    wire           grant_end = gvalid_r & done_s[grant_r];

    // Wraps from the last reader back to the first
    function [GW-1:0] next_idx;
        input [GW-1:0] i;
        begin
            next_idx = (i == NRD - 1) ? {GW{1'b0}} : i + 1'b1; // [R6] [R21]
        end
    endfunction

    // Slot counter third-step decode
    function third_step;
        input [1:0] c;
        begin
            third_step = (c == SLOT_THIRD);
        end
    endfunction

    // Each slot counts steps only while the pointer rests on it
    genvar g;
    generate
        for (g = 0; g < NRD; g = g + 1) begin : g_slot
            always @(posedge clk_i) begin
                if (rst_i) begin
                    slot_cnt_r[g] <= SLOT_IDLE;
                end else if (grant_end && grant_r == g) begin
                    slot_cnt_r[g] <= SLOT_IDLE;
                end else if (gvalid_r && grant_r == g) begin
                    slot_cnt_r[g] <= slot_cnt_r[g]; // [R4]
                end else if (step_in && ptr_r == g) begin
                    if (third_step(slot_cnt_r[g]) || !bid_prime[g])
                        slot_cnt_r[g] <= SLOT_IDLE;
                    else
                        slot_cnt_r[g] <= slot_cnt_r[g] + 2'h1;
                end
            end
        end
    endgenerate

    // Grant arbitration: one grant register keeps the line exclusive
    // Pointer walks past silent slots one per clock
    reg  [GW-1:0]  grant_nxt;
    reg            gvalid_nxt;
    reg  [GW-1:0]  ptr_nxt;
    always @* begin
        grant_nxt  = grant_r;
        gvalid_nxt = gvalid_r;
        ptr_nxt    = ptr_r;
        if (!enable) begin
            gvalid_nxt = 1'b0;
        end else if (gvalid_r) begin
            if (done_s[grant_r]) begin
                gvalid_nxt = 1'b0;
                ptr_nxt    = next_idx(grant_r); // [R6]
            end
        end else if (!bid_prime[ptr_r]) begin
            ptr_nxt = next_idx(ptr_r); // [R21]
        end else if (third_step(slot_cnt_r[ptr_r]) && char_clk_i) begin
            grant_nxt  = ptr_r; // [R1] [R3]
            gvalid_nxt = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            grant_r  <= {GW{1'b0}};
            gvalid_r <= 1'b0;
            ptr_r    <= {GW{1'b0}};
        end else begin
            grant_r  <= grant_nxt;
            gvalid_r <= gvalid_nxt;
            ptr_r    <= ptr_nxt;
        end
    end

    // Stop collection
    wire reader_stop = ~(&stop_n_s);
    wire alarm_stop  = ~alarm_n_s;
    wire remote_stop = ~rstop_n_s;
    wire stop_any    = reader_stop | alarm_stop | remote_stop; // [R12]

    // Step delay timer
    // Stop is latched over the whole delay: one raised at grant time
    // passes the synchroniser well before the delayed step is due
    reg [DW-1:0] dly_cnt_r;
    reg          dly_run_r;
    reg          stop_lat_r;
    reg          dly_done_r;
    wire         dly_last = (dly_cnt_r == DLY_LAST);
    always @(posedge clk_i) begin
        dly_done_r <= 1'b0;
        if (rst_i) begin
            dly_cnt_r  <= {DW{1'b0}};
            dly_run_r  <= 1'b0;
            stop_lat_r <= 1'b0;
        end else if (step_in) begin
            dly_cnt_r  <= {DW{1'b0}}; // [R10]
            dly_run_r  <= 1'b1;
            stop_lat_r <= stop_any; // [R14]
        end else if (dly_run_r) begin
            stop_lat_r <= stop_lat_r | stop_any;
            if (dly_last) begin
                dly_run_r  <= 1'b0;
                dly_done_r <= 1'b1;
            end else begin
                dly_cnt_r <= dly_cnt_r + 1'b1;
            end
        end
    end

    // Single-step flops: no reset, cleared by step flow
    // Request pends until the next step so a short pulse is not lost
    reg ss1_r;
    reg ss2_r;
    reg man_pend_r;
    always @(posedge clk_i) begin
        if (|man_s || |mstep_r)
            man_pend_r <= 1'b1; // [R15]
        else if (step_in)
            man_pend_r <= 1'b0;
        if (step_in) begin
            if (ss2_r) begin
                ss1_r <= 1'b0; // [R18] [R19]
                ss2_r <= 1'b0;
            end else if (ss1_r) begin
                ss2_r <= 1'b1; // [R16]
            end else begin
                ss1_r <= man_pend_r; // [R15]
                ss2_r <= 1'b0;
            end
        end
    end

    // Step pass gate; ss2 lets exactly one delayed step through a stop
    wire pass_ok = ~(stop_lat_r | stop_any) | ss2_r; // [R13] [R16]
    wire step_go = dly_done_r & pass_ok; // [R11] [R17]

    // One-hot decode of the granted reader, shared by every per-reader output
    function [NRD-1:0] grant_hot;
        input [GW-1:0] idx;
        input          vld;
        integer        j;
        begin
            for (j = 0; j < NRD; j = j + 1)
                grant_hot[j] = vld && (idx == j);
        end
    endfunction

    wire [NRD-1:0] gsel = grant_hot(grant_r, gvalid_r); // [R1]

    // Generator steps in normal mode; reader steps and alarm feed in delete mode
    always @(posedge clk_i) begin
        if (rst_i) begin
            som_step_n_o <= 1'b1;
            alarm_step_o <= 1'b0;
            step_out_o   <= 1'b0;
            step_read_o  <= 1'b0;
        end else begin
            step_out_o   <= step_go;
            step_read_o  <= read_pulse_i & rstop_n_s; // [R20]
            som_step_n_o <= ~(gvalid_r & ~delete_m & read_pulse_i
                              & rstop_n_s); // [R7] [R8]
            alarm_step_o <= gvalid_r & delete_m & step_go; // [R9]
        end
    end

    // Reset leaves every reader off line with its contacts masked
    always @(posedge clk_i) begin
        if (rst_i) begin
            online_n_o    <= {NRD{1'b1}};
            contact_en_o  <= {NRD{1'b0}};
            reader_step_o <= {NRD{1'b0}};
        end else begin
            online_n_o    <= ~gsel; // [R5]
            contact_en_o  <= gsel; // [R5]
            reader_step_o <= gsel & {NRD{delete_m & step_go}}; // [R7] [R9]
        end
    end

    // Wishbone slave: ack one cycle after the request, dropped the cycle after
    // Writes land on the edge where ack is high, as the master expects
    wire        wb_req = cyc_i & stb_i & ~ack_o;
    wire        wb_wr  = cyc_i & stb_i & ack_o & we_i & sel_i[0];
    reg  [31:0] status_w;
    reg  [31:0] rd_nxt;

    // Status word assembled from its field positions
    always @* begin
        status_w                           = 32'h0000_0000;
        status_w[`RSSG_ST_GRANT_LSB +: GW] = grant_r;
        status_w[`RSSG_ST_VALID]           = gvalid_r;
        status_w[`RSSG_ST_STOP]            = stop_any;
        status_w[`RSSG_ST_SS1]             = ss1_r;
        status_w[`RSSG_ST_SS2]             = ss2_r;
    end

    // Read mux; unmapped offsets read as zero
    always @* begin
        rd_nxt = 32'h0000_0000;
        if (wb_req && !we_i) begin
            case (adr_i)
                `RSSG_REG_CTRL:   rd_nxt = {30'h0000_0000, ctrl_r};
                `RSSG_REG_STATUS: rd_nxt = status_w;
                default:          rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Bit 1 of the control word forces delete mode alongside the pin
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o   <= 1'b0;
            dat_o   <= 32'h0000_0000;
            ctrl_r  <= `RSSG_CTRL_RESET;
            mstep_r <= {NRD{1'b0}};
        end else begin
            ack_o   <= wb_req;
            dat_o   <= rd_nxt;
            mstep_r <= {NRD{1'b0}};
            if (wb_wr && adr_i == `RSSG_REG_CTRL)
                ctrl_r <= dat_i[1:0];
            if (wb_wr && adr_i == `RSSG_REG_MSTEP)
                mstep_r <= dat_i[NRD-1:0];
        end
    end
endmodule // rssg_top

// *** bench/rssg_top_props.sv ***
`timescale 1ns/100ps
module rssg_top_props (
    input wire       clk_i,
    input wire       rst_i,
    input wire       reader_step_n_i,
    input wire       remote_stop_n_i,
    input wire [5:0] online_n_o,
    input wire [5:0] contact_en_o,
    input wire [5:0] reader_step_o,
    input wire       som_step_n_o,
    input wire       alarm_step_o,
    input wire       step_out_o,
    input wire       step_read_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_one_online: assert property ($onehot0(~online_n_o))
        else $error("two readers on line");
    a_contact_online: assert property (contact_en_o == ~online_n_o)
        else $error("contact enable differs from on-line");
    a_som_no_reader: assert property (!som_step_n_o |-> reader_step_o == 6'h00)
        else $error("reader step during generator step");
    a_step_granted: assert property (|reader_step_o |-> (reader_step_o & online_n_o) == 6'h00)
        else $error("step to reader off line");
    a_alarm_follow: assert property (|reader_step_o |-> alarm_step_o)
        else $error("reader step without alarm step");
    a_som_single: assert property (!som_step_n_o |=> som_step_n_o)
        else $error("generator step longer than one cycle");
    a_step_single: assert property (step_out_o |=> !step_out_o)
        else $error("delayed step longer than one cycle");
    a_step_delayed: assert property ($fell(reader_step_n_i) |-> !step_out_o [*8])
        else $error("delayed step came early");
    a_read_blocked: assert property (!remote_stop_n_i [*5] |-> !step_read_o)
        else $error("read pulse passed under remote stop");
    c_grant: cover property (online_n_o != 6'h3F);
    c_step: cover property (step_out_o);
    c_reader_step: cover property (|reader_step_o);
endmodule // rssg_top_props

// *** bench/rssg_reader_model.sv ***
`timescale 1ns/100ps
module rssg_reader_model #(
    parameter HOLD = 200
) (
    input  wire       clk_i,
    input  wire [5:0] want_i,
    input  wire [5:0] online_n_i,
    output reg  [5:0] bid_n_o,
    output reg  [5:0] done_o
);
    integer k;
    integer cnt [0:5];
    initial begin
        bid_n_o = 6'h3F;
        done_o = 6'h00;
        for (k = 0; k < 6; k = k + 1)
            cnt[k] = 0;
    end
    // Tape ends a fixed time after going on line; bid withdrawn once it ends
    always @(posedge clk_i) begin
        for (k = 0; k < 6; k = k + 1) begin
            bid_n_o[k] <= ~want_i[k] | done_o[k];
            if (!online_n_i[k])
                cnt[k] <= cnt[k] + 1;
            if (cnt[k] == HOLD)
                done_o[k] <= 1'b1;
            if (online_n_i[k] && done_o[k]) begin
                done_o[k] <= 1'b0;
                cnt[k] <= 0;
            end
        end
    end
endmodule // rssg_reader_model

// *** bench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    localparam DLY = 20;
    reg         clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    reg  [7:0]  adr_i = 8'h00;
    reg  [3:0]  sel_i = 4'hF;
    reg  [31:0] dat_i = 32'h0, q;
    reg  [5:0]  stop_n_i = 6'h3F, manual_step_i = 6'h00, want = 6'h00;
    reg         delete_prime_n_i = 1'b1, remote_stop_n_i = 1'b1, alarm_n_i = 1'b1;
    reg         reader_step_n_i = 1'b1, char_clk_i = 1'b1, read_pulse_i = 1'b0;
    wire [31:0] dat_o;
    wire [5:0]  bid_n_i, tx_done_i, online_n_o, contact_en_o, reader_step_o;
    wire        ack_o, som_step_n_o, alarm_step_o, step_out_o, step_read_o;
    integer     miscompares = 0, n_checks = 0, cyc_n = 0, t0 = 0, lat = 0;
    integer     n_out = 0, n_som = 0, n_rd = 0, n_al = 0, n_rdp = 0;
    rssg_top #(.DLY_CYC(DLY)) i_rssg_top (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .bid_n_i(bid_n_i), .stop_n_i(stop_n_i), .manual_step_i(manual_step_i),
        .tx_done_i(tx_done_i), .delete_prime_n_i(delete_prime_n_i),
        .remote_stop_n_i(remote_stop_n_i), .alarm_n_i(alarm_n_i),
        .reader_step_n_i(reader_step_n_i), .char_clk_i(char_clk_i),
        .read_pulse_i(read_pulse_i), .online_n_o(online_n_o),
        .contact_en_o(contact_en_o), .reader_step_o(reader_step_o),
        .som_step_n_o(som_step_n_o), .alarm_step_o(alarm_step_o),
        .step_out_o(step_out_o), .step_read_o(step_read_o));
    rssg_reader_model #(.HOLD(200)) i_rssg_reader_model (
        .clk_i(clk_i), .want_i(want), .online_n_i(online_n_o),
        .bid_n_o(bid_n_i), .done_o(tx_done_i));
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (step_out_o) begin
            n_out <= n_out + 1;
            lat <= cyc_n - t0;
        end
        if (!som_step_n_o) n_som <= n_som + 1;
        if (|reader_step_o) n_rd <= n_rd + 1;
        if (alarm_step_o) n_al <= n_al + 1;
        if (step_read_o) n_rdp <= n_rdp + 1;
    end
    task chk(input [31:0] got, input [31:0] ex);
        begin
            n_checks = n_checks + 1;
            if (got !== ex) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, ex);
            end
        end
    endtask
    task clr;
        begin
            n_out = 0; n_som = 0; n_rd = 0; n_al = 0; n_rdp = 0;
        end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
        integer t;
        begin
            t = 0;
            cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
            @(posedge clk_i);
            while (ack_o !== 1'b1 && t < 50) begin
                t = t + 1;
                @(posedge clk_i);
            end
            if (t == 50) miscompares = miscompares + 1;
            q = dat_o;
            cyc_i <= 1'b0; stb_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    // Spacing kept above the delay so pulses never overlap
    task step;
        begin
            reader_step_n_i <= 1'b0; read_pulse_i <= 1'b1; t0 = cyc_n;
            @(posedge clk_i);
            reader_step_n_i <= 1'b1; read_pulse_i <= 1'b0;
            repeat (DLY + 8) @(posedge clk_i);
        end
    endtask
    task wait_grant(input [5:0] old, input [5:0] ex);
        integer n;
        begin
            n = 0;
            while ((online_n_o === old || online_n_o === 6'h3F) && n < 60) begin
                step;
                n = n + 1;
            end
            chk(online_n_o, ex);
        end
    endtask
    task t_regs;
        begin
            wb(1'b1, 8'h00, 32'h1);
            wb(1'b0, 8'h00, 32'h0);
            chk(q, 32'h1);
            wb(1'b0, 8'h0C, 32'h0);
            chk(q, 32'h0);
        end
    endtask
    task t_pass;
        begin
            repeat (3) step;
            clr;
            step;
            chk(n_out, 1);
            chk((lat >= DLY + 1) && (lat <= DLY + 3), 1);
            chk(n_rdp, 1);
        end
    endtask
    task t_stops;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                if (i < 6) stop_n_i[i] <= 1'b0;
                alarm_n_i <= (i != 6);
                remote_stop_n_i <= (i != 7);
                repeat (4) @(posedge clk_i);
                clr;
                step;
                chk(n_out, 0);
                chk(n_rdp, (i == 7) ? 0 : 1);
                stop_n_i <= 6'h3F; alarm_n_i <= 1'b1; remote_stop_n_i <= 1'b1;
                repeat (4) @(posedge clk_i);
            end
            clr;
            stop_n_i[0] <= 1'b0;
            step;
            chk(n_out, 0);
            stop_n_i <= 6'h3F;
            repeat (4) @(posedge clk_i);
        end
    endtask
    task t_manual;
        begin
            stop_n_i[0] <= 1'b0;
            manual_step_i <= 6'h08;
            repeat (4) @(posedge clk_i);
            manual_step_i <= 6'h00;
            clr;
            repeat (4) step;
            chk(n_out, 1);
            wb(1'b1, 8'h08, 32'h01);
            clr;
            repeat (4) step;
            chk(n_out, 1);
            stop_n_i <= 6'h3F;
            repeat (4) @(posedge clk_i);
        end
    endtask
    task t_grant;
        begin
            want <= 6'h01;
            wait_grant(6'h3F, 6'h3E);
            chk(contact_en_o, 6'h01);
            wb(1'b0, 8'h04, 32'h0);
            chk(q, 32'h08);
            want <= 6'h11;
            clr;
            step;
            chk(n_som, 1);
            chk(n_rd, 0);
            chk(n_al, 0);
            delete_prime_n_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            clr;
            step;
            chk(n_rd, 1);
            chk(n_al, 1);
            delete_prime_n_i <= 1'b1;
            wb(1'b1, 8'h00, 32'h3);
            clr;
            step;
            chk(n_rd, 1);
            wb(1'b1, 8'h00, 32'h1);
            wait_grant(6'h3E, 6'h2F);
            wait_grant(6'h2F, 6'h3E);
        end
    endtask
    task print_verdict;
        begin
            if (miscompares == 0 && n_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs;
        t_pass;
        t_stops;
        t_manual;
        t_grant;
        print_verdict;
    end
    initial begin
        #1000000;
        miscompares = miscompares + 1;
        print_verdict;
    end
endmodule // testbench
bind rssg_top rssg_top_props i_rssg_top_props (
    .clk_i(clk_i), .rst_i(rst_i), .reader_step_n_i(reader_step_n_i),
    .remote_stop_n_i(remote_stop_n_i), .online_n_o(online_n_o),
    .contact_en_o(contact_en_o), .reader_step_o(reader_step_o),
    .som_step_n_o(som_step_n_o), .alarm_step_o(alarm_step_o),
    .step_out_o(step_out_o), .step_read_o(step_read_o));
